// [hdl/sigmod_top.sv]
`timescale 1ns/1ns
module sigmod_top
(
  input  wire logic                               I_CLOCK,
  input  wire logic                               I_RST,
  input  wire logic [sigmod_pkg::ADDR_W-1:0]      I_AWADDR,
  input  wire logic                               I_AWVALID,
  output logic                                    O_AWREADY,
  input  wire logic [sigmod_pkg::DATA_W-1:0]      I_WDATA,
  input  wire logic [3:0]                         I_WSTRB,
  input  wire logic                               I_WVALID,
  output logic                                    O_WREADY,
  output logic [1:0]                              O_BRESP,
  output logic                                    O_BVALID,
  input  wire logic                               I_BREADY,
  input  wire logic [sigmod_pkg::ADDR_W-1:0]      I_ARADDR,
  input  wire logic                               I_ARVALID,
  output logic                                    O_ARREADY,
  output logic [sigmod_pkg::DATA_W-1:0]           O_RDATA,
  output logic [1:0]                              O_RRESP,
  output logic                                    O_RVALID,
  input  wire logic                               I_RREADY,
  input  wire logic [sigmod_pkg::PIN_IN_N-1:0]    I_PIN,
  input  wire logic                               I_HFOSC,
  input  wire logic                               I_REFCLK,
  input  wire logic [sigmod_pkg::NUM_CCP-1:0]     I_CCP_OUT,
  input  wire logic [sigmod_pkg::NUM_PWM-1:0]     I_PWM_OUT,
  input  wire logic [sigmod_pkg::NUM_CMP-1:0]     I_CMP_OUT,
  input  wire logic [sigmod_pkg::NUM_UART-1:0]    I_UART_RX_OUT,
  input  wire logic [sigmod_pkg::NUM_UART-1:0]    I_UART_TX_OUT,
  input  wire logic [sigmod_pkg::NUM_SPI-1:0]     I_SPI_SDO,
  output logic [sigmod_pkg::PIN_OUT_N-1:0]        O_MODULATED_PIN
);

  localparam int ASYNC_N = sigmod_pkg::PIN_IN_N + 2;

  // Configuration
  logic                                 enable_ff;
  logic                                 output_invert_ff;
  logic                                 swbit_ff;
  logic                                 carrier_high_invert_ff;
  logic                                 carrier_high_sync_enable_ff;
  logic                                 carrier_low_invert_ff;
  logic                                 carrier_low_sync_enable_ff;
  logic [4:0]                           src_sel_ff;
  logic [3:0]                           chs_ff;
  logic [3:0]                           cls_ff;
  logic [sigmod_pkg::PIN_SEL_W-1:0]     mod_pin_ff;
  logic [sigmod_pkg::PIN_SEL_W-1:0]     carrier_high_pin_ff;
  logic [sigmod_pkg::PIN_SEL_W-1:0]     carrier_low_pin_ff;
  logic [sigmod_pkg::PIN_OUT_N-1:0]     route_ff;

  // Output stage
  logic                                 level_ff;
  logic                                 nxt_level;
  logic [sigmod_pkg::PIN_OUT_N-1:0]     pin_ff;
  logic                                 mix;

  // Input synchronisers
  logic [ASYNC_N-1:0]                   meta_ff;
  logic [ASYNC_N-1:0]                   sync_ff;
  logic [sigmod_pkg::PIN_IN_N-1:0]      pin_s;

  // Bus slave
  logic                                 awready_ff;
  logic                                 wready_ff;
  logic                                 aw_held_ff;
  logic                                 w_held_ff;
  logic [13:0]                          aw_idx_ff;
  logic [7:0]                           wdata_ff;
  logic                                 wlane_ff;
  logic                                 bvalid_ff;
  logic [1:0]                           bresp_ff;
  logic                                 arready_ff;
  logic                                 rvalid_ff;
  logic [sigmod_pkg::DATA_W-1:0]        rdata_ff;
  logic [1:0]                           rresp_ff;
  logic                                 aw_take;
  logic                                 w_take;
  logic                                 ar_take;
  logic                                 wr_fire;
  logic                                 nxt_aw_held;
  logic                                 nxt_w_held;
  logic                                 nxt_bvalid;
  logic                                 nxt_rvalid;
  logic [13:0]                          ar_idx;

  sigmod_if sel_bus ();

  // Mapped register test, shared by the read and write paths
  function automatic logic reg_hit(input logic [13:0] idx);
    reg_hit = (idx >= sigmod_pkg::IDX_CONTROL_0) && (idx <= sigmod_pkg::IDX_ROUTE);
  endfunction

  function automatic logic pin_pick(input logic [sigmod_pkg::PIN_IN_N-1:0] pins,
                                    input logic [sigmod_pkg::PIN_SEL_W-1:0] sel);
    pin_pick = pins[sel];
  endfunction

  // Pins and foreign oscillators are asynchronous to I_CLOCK
  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= {I_REFCLK, I_HFOSC, I_PIN};
      sync_ff <= meta_ff;
    end
  end

  assign pin_s = sync_ff[sigmod_pkg::PIN_IN_N-1:0];

  sigmod_select u_select
  (
    .i_clock    (I_CLOCK),
    .i_rst      (I_RST),
    .i_src_sel  (src_sel_ff),
    .i_chs      (chs_ff),
    .i_cls      (cls_ff),
    .i_swbit    (swbit_ff),
    .i_mod_pin  (pin_pick(pin_s, mod_pin_ff)),
    .i_carrier_high_pin (pin_pick(pin_s, carrier_high_pin_ff)),
    .i_carrier_low_pin (pin_pick(pin_s, carrier_low_pin_ff)),
    .i_hfosc    (sync_ff[sigmod_pkg::PIN_IN_N]),
    .i_refclk   (sync_ff[sigmod_pkg::PIN_IN_N + 1]),
    .i_ccp      (I_CCP_OUT),
    .i_pwm      (I_PWM_OUT),
    .i_cmp      (I_CMP_OUT),
    .i_uart_rx  (I_UART_RX_OUT),
    .i_uart_tx  (I_UART_TX_OUT),
    .i_spi_sdo  (I_SPI_SDO),
    .bus        (sel_bus.sel)
  );

  sigmod_mixer u_mixer
  (
    .i_clock  (I_CLOCK),
    .i_rst    (I_RST),
    .i_carrier_high_invert  (carrier_high_invert_ff),
    .i_carrier_low_invert  (carrier_low_invert_ff),
    .i_carrier_high_sync_enable (carrier_high_sync_enable_ff),
    .i_carrier_low_sync_enable (carrier_low_sync_enable_ff),
    .bus      (sel_bus.mix),
    .o_mix    (mix)
  );

  // Disabling gates only the output; the selections stay as written
  assign nxt_level = enable_ff ? (mix ^ output_invert_ff) : 1'b0;

  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
    begin
      level_ff <= 1'b0;
      pin_ff   <= '0;
    end
    else
    begin
      level_ff <= nxt_level;
      pin_ff   <= {sigmod_pkg::PIN_OUT_N{nxt_level}} & route_ff;
    end
  end

  assign O_MODULATED_PIN = pin_ff;

  // Write address and data are taken separately and applied together
  assign aw_take = I_AWVALID & awready_ff;
  assign w_take  = I_WVALID & wready_ff;
  assign wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;

  always_comb
  begin
    nxt_aw_held = aw_held_ff | aw_take;
    nxt_w_held  = w_held_ff | w_take;
    nxt_bvalid  = bvalid_ff & ~I_BREADY;
    if (wr_fire)
    begin
      nxt_aw_held = 1'b0;
      nxt_w_held  = 1'b0;
      nxt_bvalid  = 1'b1;
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
    begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= sigmod_pkg::RESP_OKAY;
      aw_idx_ff  <= '0;
      wdata_ff   <= '0;
      wlane_ff   <= 1'b0;
    end
    else
    begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff  <= nxt_w_held;
      awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
      wready_ff  <= ~nxt_w_held & ~nxt_bvalid;
      bvalid_ff  <= nxt_bvalid;
      if (aw_take)
        aw_idx_ff <= I_AWADDR[15:2];
      if (w_take)
      begin
        wdata_ff <= I_WDATA[7:0];
        wlane_ff <= I_WSTRB[0];
      end
      if (wr_fire)
        bresp_ff <= reg_hit(aw_idx_ff) ? sigmod_pkg::RESP_OKAY : sigmod_pkg::RESP_SLVERR;
    end
  end

  // Only byte lane 0 carries register bits; other lanes are dropped
  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
    begin
      enable_ff   <= 1'b0;
      output_invert_ff     <= 1'b0;
      swbit_ff    <= 1'b0;
      carrier_high_invert_ff    <= 1'b0;
      carrier_high_sync_enable_ff   <= 1'b0;
      carrier_low_invert_ff    <= 1'b0;
      carrier_low_sync_enable_ff   <= 1'b0;
      src_sel_ff  <= sigmod_pkg::RST_SOURCE;
      chs_ff      <= sigmod_pkg::RST_CARRIER;
      cls_ff      <= sigmod_pkg::RST_CARRIER;
      mod_pin_ff  <= sigmod_pkg::RST_PIN_SEL;
      carrier_high_pin_ff <= sigmod_pkg::RST_PIN_SEL;
      carrier_low_pin_ff <= sigmod_pkg::RST_PIN_SEL;
      route_ff    <= sigmod_pkg::RST_ROUTE;
    end
    else if (wr_fire && wlane_ff)
    begin
      case (aw_idx_ff)
        sigmod_pkg::IDX_CONTROL_0:
        begin
          enable_ff <= wdata_ff[sigmod_pkg::C0_ENABLE];
          output_invert_ff   <= wdata_ff[sigmod_pkg::C0_OUTPUT_INVERT];
          swbit_ff  <= wdata_ff[sigmod_pkg::C0_SWBIT];
        end
        sigmod_pkg::IDX_CONTROL_1:
        begin
          carrier_high_invert_ff  <= wdata_ff[sigmod_pkg::C1_CARRIER_HIGH_INVERT];
          carrier_high_sync_enable_ff <= wdata_ff[sigmod_pkg::C1_CARRIER_HIGH_SYNC_ENABLE];
          carrier_low_invert_ff  <= wdata_ff[sigmod_pkg::C1_CARRIER_LOW_INVERT];
          carrier_low_sync_enable_ff <= wdata_ff[sigmod_pkg::C1_CARRIER_LOW_SYNC_ENABLE];
        end
        sigmod_pkg::IDX_SOURCE:       src_sel_ff  <= wdata_ff[4:0];
        sigmod_pkg::IDX_CARRIER_LOW:  cls_ff      <= wdata_ff[3:0];
        sigmod_pkg::IDX_CARRIER_HIGH: chs_ff      <= wdata_ff[3:0];
        sigmod_pkg::IDX_MOD_PIN:      mod_pin_ff  <= wdata_ff[sigmod_pkg::PIN_SEL_W-1:0];
        sigmod_pkg::IDX_CARRIER_HIGH_PIN:     carrier_high_pin_ff <= wdata_ff[sigmod_pkg::PIN_SEL_W-1:0];
        sigmod_pkg::IDX_CARRIER_LOW_PIN:     carrier_low_pin_ff <= wdata_ff[sigmod_pkg::PIN_SEL_W-1:0];
        sigmod_pkg::IDX_ROUTE:        route_ff    <= wdata_ff[sigmod_pkg::PIN_OUT_N-1:0];
        default:                      route_ff    <= route_ff;
      endcase
    end
  end

  // Reads are answered one cycle after the address is taken
  assign ar_take    = I_ARVALID & arready_ff;
  assign ar_idx     = I_ARADDR[15:2];
  assign nxt_rvalid = ar_take | (rvalid_ff & ~I_RREADY);

  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
    begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= '0;
      rresp_ff   <= sigmod_pkg::RESP_OKAY;
    end
    else
    begin
      arready_ff <= ~nxt_rvalid;
      rvalid_ff  <= nxt_rvalid;
      if (ar_take)
      begin
        rdata_ff <= '0;
        rresp_ff <= reg_hit(ar_idx) ? sigmod_pkg::RESP_OKAY : sigmod_pkg::RESP_SLVERR;
        case (ar_idx)
          sigmod_pkg::IDX_CONTROL_0:
          begin
            rdata_ff[sigmod_pkg::C0_ENABLE] <= enable_ff;
            rdata_ff[sigmod_pkg::C0_OUT]    <= level_ff;
            rdata_ff[sigmod_pkg::C0_OUTPUT_INVERT]   <= output_invert_ff;
            rdata_ff[sigmod_pkg::C0_SWBIT]  <= swbit_ff;
          end
          sigmod_pkg::IDX_CONTROL_1:
          begin
            rdata_ff[sigmod_pkg::C1_CARRIER_HIGH_INVERT]  <= carrier_high_invert_ff;
            rdata_ff[sigmod_pkg::C1_CARRIER_HIGH_SYNC_ENABLE] <= carrier_high_sync_enable_ff;
            rdata_ff[sigmod_pkg::C1_CARRIER_LOW_INVERT]  <= carrier_low_invert_ff;
            rdata_ff[sigmod_pkg::C1_CARRIER_LOW_SYNC_ENABLE] <= carrier_low_sync_enable_ff;
          end
          sigmod_pkg::IDX_SOURCE:       rdata_ff[4:0] <= src_sel_ff;
          sigmod_pkg::IDX_CARRIER_LOW:  rdata_ff[3:0] <= cls_ff;
          sigmod_pkg::IDX_CARRIER_HIGH: rdata_ff[3:0] <= chs_ff;
          sigmod_pkg::IDX_MOD_PIN:      rdata_ff[2:0] <= mod_pin_ff;
          sigmod_pkg::IDX_CARRIER_HIGH_PIN:     rdata_ff[2:0] <= carrier_high_pin_ff;
          sigmod_pkg::IDX_CARRIER_LOW_PIN:     rdata_ff[2:0] <= carrier_low_pin_ff;
          sigmod_pkg::IDX_ROUTE:        rdata_ff[3:0] <= route_ff;
          default:                      rdata_ff      <= '0;
        endcase
      end
    end
  end

  assign O_AWREADY = awready_ff;
  assign O_WREADY  = wready_ff;
  assign O_BVALID  = bvalid_ff;
  assign O_BRESP   = bresp_ff;
  assign O_ARREADY = arready_ff;
  assign O_RVALID  = rvalid_ff;
  assign O_RDATA   = rdata_ff;
  assign O_RRESP   = rresp_ff;

endmodule

// [hdl/sigmod_pkg.sv]
package sigmod_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [13:0] IDX_CONTROL_0      = 14'h0F51;
  localparam logic [13:0] IDX_CONTROL_1      = 14'h0F52;
  localparam logic [13:0] IDX_SOURCE         = 14'h0F53;
  localparam logic [13:0] IDX_CARRIER_LOW    = 14'h0F54;
  localparam logic [13:0] IDX_CARRIER_HIGH   = 14'h0F55;
  localparam logic [13:0] IDX_MOD_PIN        = 14'h0F56;
  localparam logic [13:0] IDX_CARRIER_HIGH_PIN       = 14'h0F57;
  localparam logic [13:0] IDX_CARRIER_LOW_PIN       = 14'h0F58;
  localparam logic [13:0] IDX_ROUTE          = 14'h0F59;

  localparam int ADDR_W      = 16;
  localparam int DATA_W      = 32;
  localparam int PIN_IN_N    = 8;
  localparam int PIN_SEL_W   = 3;
  localparam int PIN_OUT_N   = 4;
  localparam int NUM_CCP     = 5;
  localparam int NUM_PWM     = 2;
  localparam int NUM_CMP     = 3;
  localparam int NUM_UART    = 5;
  localparam int NUM_SPI     = 2;

  // Control 0 fields
  localparam int C0_ENABLE   = 7;
  localparam int C0_OUT      = 5;
  localparam int C0_OUTPUT_INVERT     = 4;
  localparam int C0_SWBIT    = 0;
  // Control 1 fields
  localparam int C1_CARRIER_HIGH_INVERT    = 5;
  localparam int C1_CARRIER_HIGH_SYNC_ENABLE   = 4;
  localparam int C1_CARRIER_LOW_INVERT    = 1;
  localparam int C1_CARRIER_LOW_SYNC_ENABLE   = 0;

  // Reset values
  localparam logic [4:0]           RST_SOURCE  = 5'h00;
  localparam logic [3:0]           RST_CARRIER = 4'h0;
  localparam logic [PIN_SEL_W-1:0] RST_PIN_SEL = 3'h0;
  localparam logic [PIN_OUT_N-1:0] RST_ROUTE   = 4'h1;

  // Modulator source codes
  localparam logic [4:0] SRC_PIN      = 5'h00;
  localparam logic [4:0] SRC_SWBIT    = 5'h01;
  localparam logic [4:0] SRC_CCP_BASE = 5'h02;
  localparam logic [4:0] SRC_PWM_BASE = 5'h07;
  localparam logic [4:0] SRC_CMP_BASE = 5'h09;
  localparam logic [4:0] SRC_UART_BASE = 5'h0C;
  localparam logic [4:0] SRC_SPI_BASE = 5'h16;
  localparam logic [4:0] SRC_LAST     = 5'h17;
  localparam int         SRC_N        = 24;

  // Carrier source codes
  localparam logic [3:0] CAR_PIN      = 4'h0;
  localparam logic [3:0] CAR_FOSC     = 4'h1;
  localparam logic [3:0] CAR_HFOSC    = 4'h2;
  localparam logic [3:0] CAR_REFCLK   = 4'h3;
  localparam logic [3:0] CAR_CCP_BASE = 4'h4;
  localparam logic [3:0] CAR_PWM_BASE = 4'h9;
  localparam logic [3:0] CAR_LAST     = 4'hA;
  localparam int         CAR_N        = 11;

  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

endpackage

// [hdl/sigmod_if.sv]
`timescale 1ns/1ns
interface sigmod_if;
  logic carrier_high;
  logic carrier_low;
  logic modsig;

  modport sel (output carrier_high, output carrier_low, output modsig);
  modport mix (input carrier_high, input carrier_low, input modsig);
endinterface

// [hdl/sigmod_select.sv]
`timescale 1ns/1ns
module sigmod_select
(
  input  wire logic                               i_clock,
  input  wire logic                               i_rst,
  input  wire logic [4:0]                         i_src_sel,
  input  wire logic [3:0]                         i_chs,
  input  wire logic [3:0]                         i_cls,
  input  wire logic                               i_swbit,
  input  wire logic                               i_mod_pin,
  input  wire logic                               i_carrier_high_pin,
  input  wire logic                               i_carrier_low_pin,
  input  wire logic                               i_hfosc,
  input  wire logic                               i_refclk,
  input  wire logic [sigmod_pkg::NUM_CCP-1:0]     i_ccp,
  input  wire logic [sigmod_pkg::NUM_PWM-1:0]     i_pwm,
  input  wire logic [sigmod_pkg::NUM_CMP-1:0]     i_cmp,
  input  wire logic [sigmod_pkg::NUM_UART-1:0]    i_uart_rx,
  input  wire logic [sigmod_pkg::NUM_UART-1:0]    i_uart_tx,
  input  wire logic [sigmod_pkg::NUM_SPI-1:0]     i_spi_sdo,
  sigmod_if.sel                                   bus
);

  logic                               fosc_ff;
  logic [sigmod_pkg::CAR_N-1:0]       car_vec;
  logic [sigmod_pkg::SRC_N-1:0]       mod_vec;

  // Carrier code lookup; reserved codes give a steady low
  function automatic logic pick_car(input logic [sigmod_pkg::CAR_N-1:0] vec,
                                    input logic [3:0] code);
    pick_car = (code <= sigmod_pkg::CAR_LAST) ? vec[code] : 1'b0;
  endfunction

  // A clock cannot pass through flops, so the system clock carrier is its
  // fastest sampled image: a toggle at half rate
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      fosc_ff <= 1'b0;
    else
      fosc_ff <= ~fosc_ff;
  end

  always_comb
  begin
    car_vec = {i_pwm, i_ccp, i_refclk, i_hfosc, fosc_ff, 1'b0};
    car_vec[sigmod_pkg::CAR_PIN] = 1'b0;
  end

  always_comb
  begin
    mod_vec = '0;
    mod_vec[sigmod_pkg::SRC_PIN]   = i_mod_pin;
    mod_vec[sigmod_pkg::SRC_SWBIT] = i_swbit;
    for (int k = 0; k < sigmod_pkg::NUM_CCP; k++)
      mod_vec[sigmod_pkg::SRC_CCP_BASE + k] = i_ccp[k];
    for (int k = 0; k < sigmod_pkg::NUM_PWM; k++)
      mod_vec[sigmod_pkg::SRC_PWM_BASE + k] = i_pwm[k];
    for (int k = 0; k < sigmod_pkg::NUM_CMP; k++)
      mod_vec[sigmod_pkg::SRC_CMP_BASE + k] = i_cmp[k];
    for (int k = 0; k < sigmod_pkg::NUM_UART; k++)
    begin
      mod_vec[sigmod_pkg::SRC_UART_BASE + 2 * k]     = i_uart_rx[k];
      mod_vec[sigmod_pkg::SRC_UART_BASE + 2 * k + 1] = i_uart_tx[k];
    end
    for (int k = 0; k < sigmod_pkg::NUM_SPI; k++)
      mod_vec[sigmod_pkg::SRC_SPI_BASE + k] = i_spi_sdo[k];
  end

  assign bus.modsig = (i_src_sel <= sigmod_pkg::SRC_LAST) ? mod_vec[i_src_sel] : 1'b0;
  assign bus.carrier_high = (i_chs == sigmod_pkg::CAR_PIN) ? i_carrier_high_pin : pick_car(car_vec, i_chs);
  assign bus.carrier_low = (i_cls == sigmod_pkg::CAR_PIN) ? i_carrier_low_pin : pick_car(car_vec, i_cls);

endmodule

// [hdl/sigmod_mixer.sv]
`timescale 1ns/1ns
module sigmod_mixer
(
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_carrier_high_invert,
  input  wire logic i_carrier_low_invert,
  input  wire logic i_carrier_high_sync_enable,
  input  wire logic i_carrier_low_sync_enable,
  sigmod_if.mix     bus,
  output logic      o_mix
);

  logic carrier_high;
  logic carrier_low;
  logic use_high_ff;
  logic nxt_use_high;
  logic hold;

  assign carrier_high = bus.carrier_high ^ i_carrier_high_invert;
  assign carrier_low = bus.carrier_low ^ i_carrier_low_invert;

  // Which carrier is mixed lags the modulator only while a synchronised
  // carrier still has its pulse high, so that pulse is never cut short
  // Without sync the switch is immediate; only a held pulse delays it
  always_comb
  begin
    hold = (use_high_ff && !bus.modsig && i_carrier_high_sync_enable && carrier_high)
           || (!use_high_ff && bus.modsig && i_carrier_low_sync_enable && carrier_low);
    nxt_use_high = hold ? use_high_ff : bus.modsig;
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      use_high_ff <= 1'b0;
    else
      use_high_ff <= nxt_use_high;
  end

  // While switching is held back the old carrier passes alone
  always_comb
  begin
    if (hold)
      o_mix = use_high_ff ? carrier_high : carrier_low;
    else if (bus.modsig)
      o_mix = carrier_high & bus.modsig;
    else
      o_mix = carrier_low & ~bus.modsig;
  end

endmodule

// [test/sigmod_props.sv]
`timescale 1ns/1ns
module sigmod_props
(
  input wire logic        I_CLOCK,
  input wire logic        I_RST,
  input wire logic [15:0] I_AWADDR,
  input wire logic        I_AWVALID,
  input wire logic        O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0]  I_WSTRB,
  input wire logic        I_WVALID,
  input wire logic        O_WREADY,
  input wire logic [1:0]  O_BRESP,
  input wire logic        O_BVALID,
  input wire logic        I_BREADY,
  input wire logic        I_ARVALID,
  input wire logic        O_ARREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic        O_RVALID,
  input wire logic        I_RREADY,
  input wire logic [3:0]  O_MODULATED_PIN
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  logic [13:0] wa_ff;
  logic [1:0]  wd_ff;
  logic        en_ff;
  always_ff @(posedge I_CLOCK)
    if (I_AWVALID && O_AWREADY)
      wa_ff <= I_AWADDR[15:2];
  always_ff @(posedge I_CLOCK)
    if (I_WVALID && O_WREADY)
      wd_ff <= {I_WSTRB[0], I_WDATA[7]};
  // Mirror of the enable bit, taken when the write is answered so it lines up with the pins
  always_ff @(posedge I_CLOCK or posedge I_RST)
    if (I_RST)
      en_ff <= 1'b0;
    else if ($rose(O_BVALID) && O_BRESP == 2'h0 && wa_ff == sigmod_pkg::IDX_CONTROL_0
             && wd_ff[1])
      en_ff <= wd_ff[0];
  // Pins follow the enable bit one edge after the register update
  property p_off; !en_ff && !$past(en_ff) |-> O_MODULATED_PIN == 4'h0; endproperty
  a_off: assert property (p_off) else $error("pins active while off");
  property p_aw_ref; I_AWVALID && O_AWREADY |=> !O_AWREADY; endproperty
  a_aw_ref: assert property (p_aw_ref) else $error("second address taken");
  property p_b_lat; I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |=> !O_BVALID ##1 O_BVALID;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  property p_b_hold; O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_ar_lat; I_ARVALID && O_ARREADY |=> O_RVALID; endproperty
  a_ar_lat: assert property (p_ar_lat) else $error("read answer late");
  property p_r_hold; O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_ar_ref; O_RVALID |-> !O_ARREADY; endproperty
  a_ar_ref: assert property (p_ar_ref) else $error("read taken while busy");
  property p_rsvd; O_RVALID |-> O_RDATA[31:8] == 24'h000000; endproperty
  a_rsvd: assert property (p_rsvd) else $error("upper read bits set");
  c_bwait: cover property (O_BVALID && !I_BREADY);
  c_all: cover property (en_ff && O_MODULATED_PIN == 4'hF);
  c_rb: cover property (O_RVALID && O_RDATA[5]);
endmodule
bind sigmod_top sigmod_props i_props
(
  .I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_AWADDR(I_AWADDR), .I_AWVALID(I_AWVALID),
  .O_AWREADY(O_AWREADY), .I_WDATA(I_WDATA), .I_WSTRB(I_WSTRB), .I_WVALID(I_WVALID),
  .O_WREADY(O_WREADY), .O_BRESP(O_BRESP), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY),
  .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RVALID(O_RVALID),
  .I_RREADY(I_RREADY), .O_MODULATED_PIN(O_MODULATED_PIN)
);

// [test/sigmod_src.sv]
`timescale 1ns/1ns
module sigmod_src
(
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic [21:0] i_pat,
  input  wire logic [7:0]  i_lvl,
  output logic [21:0]      o_per,
  output logic [7:0]       o_pin,
  output logic [1:0]       o_osc
);
  // Peripheral levels change only on the system clock, like the real units
  always_ff @(posedge i_clock)
    o_per <= i_pat;
  always_ff @(posedge i_clock)
    o_pin <= i_lvl;
  // Oscillators run free so their carrier codes never see a frozen line
  always_ff @(posedge i_clock or posedge i_rst)
    if (i_rst)
      o_osc <= 2'h0;
    else
      o_osc <= o_osc + 2'h1;
endmodule

// [test/sigmod_top_tb.sv]
`timescale 1ns/1ns
module sigmod_top_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] awaddr = 16'h0000;
  logic [15:0] araddr = 16'h0000;
  logic [31:0] wdata = 32'h00000000;
  logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic        awrdy, wrdy, bvld, arrdy, rvld;
  logic [1:0]  bresp, rresp, osc, rd_r;
  logic [31:0] rdata, rd_d;
  logic [21:0] pat = 22'h000000, per, p;
  logic [7:0]  lvl = 8'h00, pin;
  logic [3:0]  mpin;
  logic [4:0]  c;
  logic [12:0] r;
  int          i, n_errors = 0, checked = 0;
  // Row: control_1, output invert, modulator, carrier high, carrier low, expected pin
  logic [12:0] rows [8] = '{13'h000D, 13'h000A, 13'h0003, 13'h0004,
                            13'h0409, 13'h0041, 13'h001C, 13'h0015};
  initial
    forever #20 clk = ~clk;
  sigmod_src i_src
  (
    .i_clock(clk), .i_rst(rst), .i_pat(pat), .i_lvl(lvl), .o_per(per), .o_pin(pin), .o_osc(osc)
  );
  sigmod_top i_dut
  (
    .I_CLOCK(clk), .I_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awv), .O_AWREADY(awrdy),
    .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wrdy), .O_BRESP(bresp),
    .O_BVALID(bvld), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arv),
    .O_ARREADY(arrdy), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvld), .I_RREADY(rready),
    .I_PIN(pin), .I_HFOSC(osc[0]), .I_REFCLK(osc[1]), .I_CCP_OUT(per[4:0]),
    .I_PWM_OUT(per[6:5]), .I_CMP_OUT(per[9:7]), .I_UART_RX_OUT(per[14:10]),
    .I_UART_TX_OUT(per[19:15]), .I_SPI_SDO(per[21:20]), .O_MODULATED_PIN(mpin)
  );
  task automatic stop_test();
    if (n_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic tmo();
    n_errors++;
    stop_test();
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      n_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Ready is raised late on purpose so the answer has to be held
  task automatic bus(input logic w, input logic [13:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    awaddr <= {a, 2'b00};
    araddr <= {a, 2'b00};
    wdata <= {24'h000000, d};
    {awv, wv, arv} <= {w, w, !w};
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (awv && awrdy === 1'b1)
        awv <= 1'b0;
      if (wv && wrdy === 1'b1)
        wv <= 1'b0;
      if (arv && arrdy === 1'b1)
        arv <= 1'b0;
      if (n == 2)
        {bready, rready} <= {w, !w};
      rd_d = rdata;
      rd_r = w ? bresp : rresp;
      if (n > 2 && (w ? bvld : rvld) === 1'b1)
        break;
    end
    {bready, rready} <= 2'h0;
    if (n == 20)
      tmo();
  endtask
  task automatic po(input logic [3:0] m);
    repeat (6) @(posedge clk);
    chk({28'h0000000, mpin}, {28'h0000000, m});
  endtask
  function automatic int ix(input logic [4:0] s);
    if (s > 5'h17)
      return 22;
    if (s < 5'h0C || s > 5'h15)
      return int'(s) - 2;
    return s[0] ? 15 + (int'(s) - 13) / 2 : 10 + (int'(s) - 12) / 2;
  endfunction
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, sigmod_pkg::IDX_ROUTE, 8'h00);
    chk(rd_d, 32'h00000001);
    bus(1'b0, sigmod_pkg::IDX_CONTROL_0, 8'h00);
    chk(rd_d, 32'h00000000);
    bus(1'b1, sigmod_pkg::IDX_SOURCE, 8'h09);
    bus(1'b1, sigmod_pkg::IDX_CARRIER_HIGH, 8'h04);
    bus(1'b1, sigmod_pkg::IDX_CARRIER_LOW, 8'h05);
    pat <= 22'h3FFFFF;
    po(4'h0);
    for (int k = 0; k < 8; k++)
    begin
      r = rows[k];
      bus(1'b1, sigmod_pkg::IDX_CONTROL_1, r[12:5]);
      bus(1'b1, sigmod_pkg::IDX_CONTROL_0, {3'b100, r[4], 4'h0});
      pat <= {14'h0000, r[3], 5'h00, r[1], r[2]};
      po({3'b000, r[0]});
      bus(1'b0, sigmod_pkg::IDX_CONTROL_0, 8'h00);
      chk({31'h0, rd_d[5]}, {31'h0, r[0]});
    end
    bus(1'b1, sigmod_pkg::IDX_CONTROL_1, 8'h00);
    bus(1'b1, sigmod_pkg::IDX_CONTROL_0, 8'h80);
    bus(1'b1, sigmod_pkg::IDX_CARRIER_HIGH, 8'h09);
    bus(1'b1, sigmod_pkg::IDX_CARRIER_LOW, 8'h0A);
    for (int k = 4; k < 50; k++)
    begin
      c = 5'(k / 2);
      i = ix(c);
      if (k % 2 == 0)
        bus(1'b1, sigmod_pkg::IDX_SOURCE, {3'b000, c});
      p = (k % 2 == 0) ? 22'h000020 | (22'h1 << i) : ~(22'h000040 | (22'h1 << i));
      pat <= p;
      po({3'b000, (i < 22 && p[i] === 1'b1) ? p[5] : p[6]});
    end
    bus(1'b1, sigmod_pkg::IDX_SOURCE, 8'h01);
    pat <= 22'h000020;
    bus(1'b1, sigmod_pkg::IDX_CONTROL_0, 8'h81);
    po(4'h1);
    bus(1'b1, sigmod_pkg::IDX_CONTROL_0, 8'h80);
    po(4'h0);
    bus(1'b1, sigmod_pkg::IDX_MOD_PIN, 8'h03);
    bus(1'b1, sigmod_pkg::IDX_SOURCE, 8'h00);
    lvl <= 8'h08;
    po(4'h1);
    lvl <= 8'hF7;
    po(4'h0);
    lvl <= 8'h08;
    bus(1'b1, sigmod_pkg::IDX_ROUTE, 8'h0F);
    po(4'hF);
    bus(1'b1, sigmod_pkg::IDX_CONTROL_0, 8'h10);
    po(4'h0);
    bus(1'b1, sigmod_pkg::IDX_CONTROL_0, 8'h80);
    po(4'hF);
    bus(1'b1, sigmod_pkg::IDX_CONTROL_1, 8'h10);
    lvl <= 8'h00;
    po(4'hF);
    pat <= 22'h000000;
    po(4'h0);
    bus(1'b0, 14'h0000, 8'h00);
    chk({30'h0, rd_r}, {30'h0, sigmod_pkg::RESP_SLVERR});
    chk(rd_d, 32'h00000000);
    stop_test();
  end
endmodule
